// ===== e1ia_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "e1ia_regs.svh"

module e1ia_top (
    // Clock and reset.
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // Microport access and read data bus.
    input  wire e1ia_pkg::e1ia_bus_req_t req,
    output logic [7:0]                  rdata,
    output logic                        rdata_oe_n,
    // Event sources and the initialisation pin.
    input  wire e1ia_pkg::e1ia_events_t ev,
    input  wire logic                   transmit_alarm_pin,
    // Open-drain interrupt request, low level when enabled.
    output logic                        interrupt_request_n_out,
    output logic                        interrupt_request_n_oe_n
);

    // Mask words, a set bit masks its source.
    logic [7:0] nat_mask_r;                  // National use word.
    logic [7:0] mask0_r;                     // Word zero.
    logic [7:0] mask1_r;                     // Word one.
    logic [7:0] mask2_r;                     // Word two.
    logic [7:0] mask3_r;                     // Word three.
    logic [7:0] hdlc_mask_r [2];             // One per HDLC controller.
    // Control words.
    logic [7:0] mode_r;                      // Holds the soft reset bit.
    logic [7:0] irq_ctrl_r;                  // Suspend and acknowledge.
    // Status state.
    logic [7:0] vector_r;                    // Latched categories.
    logic [7:0] vector_nxt;                  // Next vector value.
    logic [7:0] alarm_latch_r;               // Sticky alarm record.
    logic [7:0] alarm_latch_nxt;             // Next latch value.
    logic [7:0] rdata_nxt;                   // Read multiplexer.
    // Decode and control terms.
    logic       wr_acc;                      // Write strobe taken.
    logic       rd_acc;                      // Read strobe taken.
    logic       on_ctrl;                     // Control page selected.
    logic       on_status;                   // Status page selected.
    logic       soft_rst;                    // Soft reset level.
    logic       suspend;                     // Interrupts held off.
    logic       ack_toggle;                  // Acknowledge bit flipped.
    logic       vec_read;                    // Vector is being read.
    logic       vec_clear;                   // Vector is wiped.
    // Per word unmasked hits.
    logic [7:0] w0_hit;                      // Word zero sources.
    logic [7:0] w1_hit;                      // Word one sources.
    logic [7:0] w2_hit;                      // Word two sources.
    logic [5:0] w3_hit;                      // Word three sources.
    logic [6:0] nat_hit;                     // National use sources.
    logic [1:0] hdlc_hit;                    // One per HDLC controller.
    logic [7:0] cat_hit;                     // Per category hits.
    logic [7:0] cat_set;                     // Hits let through.
    logic [7:0] alarm_ev;                    // Alarms for the latch.

    // Strobes are one-cycle pulses while the chip is selected.
    assign wr_acc    = req.cs & req.wr;
    assign rd_acc    = req.cs & req.rd;
    assign on_ctrl   = (req.page == `E1IA_PAGE_CTRL1);
    assign on_status = (req.page == `E1IA_PAGE_STATUS);

    // Soft reset acts for as long as its bit is high, like the pin.
    assign soft_rst = mode_r[`E1IA_BIT_SOFT_RESET];

    // Either the bit or a low pin holds every request off.
    assign suspend = irq_ctrl_r[`E1IA_BIT_SUSPEND]
                   | ~transmit_alarm_pin;

    // Any change of the acknowledge bit counts, either direction.
    assign ack_toggle = wr_acc & on_ctrl
                      & (req.addr == `E1IA_ADDR_IRQ_CTRL)
                      & (req.wdata[`E1IA_BIT_ACK]
                         != irq_ctrl_r[`E1IA_BIT_ACK]);

    assign vec_read  = rd_acc & on_status
                     & (req.addr == `E1IA_ADDR_VECTOR);
    assign vec_clear = vec_read | ack_toggle | soft_rst;

    // Each source is gated by its own mask bit before grouping.
    assign w0_hit  = ev.word0 & ~mask0_r;
    assign w1_hit  = ev.word1 & ~mask1_r;
    assign w2_hit  = ev.word2 & ~mask2_r;
    assign w3_hit  = ev.word3 & ~mask3_r[7:2];
    assign nat_hit = ev.national & ~nat_mask_r[6:0];

    // Group the sources into their eight categories.
    always_comb begin
        cat_hit = 8'h00;
        cat_hit[`E1IA_CAT_SYNC]     = w0_hit[7] | (|w3_hit[5:3]);
        cat_hit[`E1IA_CAT_ALARM]    = (|w0_hit[6:3]) | w2_hit[1];
        cat_hit[`E1IA_CAT_CNT_IND]  = (|w1_hit[7:1]) | w0_hit[2];
        cat_hit[`E1IA_CAT_CNT_OVF]  = w2_hit[7] | w2_hit[6]
                                    | w2_hit[4] | w2_hit[2]
                                    | w2_hit[0] | w0_hit[1];
        cat_hit[`E1IA_CAT_ONE_SEC]  = w3_hit[2] | w2_hit[5]
                                    | w3_hit[1] | w3_hit[0];
        cat_hit[`E1IA_CAT_SLIP]     = w0_hit[0] | w2_hit[3];
        cat_hit[`E1IA_CAT_NATIONAL] = (|nat_hit) | hdlc_hit[0];
        cat_hit[`E1IA_CAT_SIGNAL]   = w1_hit[0] | hdlc_hit[1];
    end

    // While suspended or in soft reset nothing reaches the vector.
    assign cat_set = (suspend | soft_rst) ? 8'h00 : cat_hit;

    // A new event in a read or acknowledge clearing cycle survives the clear.
    assign vector_nxt = (vec_clear ? 8'h00 : vector_r) | cat_set;

    // Alarm latch bits: sync, remote, AIS, AIS16, LOS, aux, Y, MF sync.
    assign alarm_ev = {ev.word0[7:3], ev.word2[1],
                       ev.word3[3], ev.word3[5]};
    assign alarm_latch_nxt =
        ((rd_acc & on_status & (req.addr == `E1IA_ADDR_ALARM_LATCH))
         ? 8'h00 : alarm_latch_r) | alarm_ev;

    // The two HDLC controllers share one structure on their own pages.
    for (genvar i = 0; i < 2; i++) begin : g_hdlc
        localparam logic [4:0] PAGE = (i == 0) ? `E1IA_PAGE_HDLC_A
                                               : `E1IA_PAGE_HDLC_B;
        // Masks every status source after reset, software opens them.
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                hdlc_mask_r[i] <= `E1IA_RST_MASKED;
            end else if (soft_rst) begin
                hdlc_mask_r[i] <= `E1IA_RST_MASKED;
            end else if (wr_acc && req.page == PAGE &&
                         req.addr == `E1IA_ADDR_HDLC_MASK) begin
                hdlc_mask_r[i] <= req.wdata;
            end
        end
        // Any unmasked HDLC source feeds that controller's category.
        assign hdlc_hit[i] = |(ev.hdlc[i] & ~hdlc_mask_r[i]);
    end

    // Mask words on the control page; soft reset forces their defaults.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            nat_mask_r <= `E1IA_NAT_USED;
            mask0_r    <= `E1IA_RST_CLEAR;
            mask1_r    <= `E1IA_RST_MASKED;
            mask2_r    <= `E1IA_RST_MASKED;
            mask3_r    <= `E1IA_MASK3_USED;
        end else if (soft_rst) begin
            nat_mask_r <= `E1IA_NAT_USED;
            mask0_r    <= `E1IA_RST_CLEAR;
            mask1_r    <= `E1IA_RST_MASKED;
            mask2_r    <= `E1IA_RST_MASKED;
            mask3_r    <= `E1IA_MASK3_USED;
        end else if (wr_acc && on_ctrl) begin
            // Unused bits are not stored, so they read back as zero.
            case (req.addr)
                `E1IA_ADDR_NAT_MASK: begin
                    nat_mask_r <= req.wdata & `E1IA_NAT_USED;
                end
                `E1IA_ADDR_MASK0: begin
                    mask0_r <= req.wdata;
                end
                `E1IA_ADDR_MASK1: begin
                    mask1_r <= req.wdata;
                end
                `E1IA_ADDR_MASK2: begin
                    mask2_r <= req.wdata;
                end
                `E1IA_ADDR_MASK3: begin
                    mask3_r <= req.wdata & `E1IA_MASK3_USED;
                end
                default: begin
                end
            endcase
        end
    end

    // Control words stay writable in soft reset so it can be lifted.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_r     <= `E1IA_RST_CLEAR;
            irq_ctrl_r <= `E1IA_RST_CLEAR;
        end else if (wr_acc && on_ctrl) begin
            if (req.addr == `E1IA_ADDR_MODE) begin
                mode_r <= req.wdata;
            end
            if (req.addr == `E1IA_ADDR_IRQ_CTRL) begin
                irq_ctrl_r <= req.wdata;
            end
        end
    end

    // Vector and alarm latch update every cycle.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            vector_r      <= `E1IA_RST_CLEAR;
            alarm_latch_r <= `E1IA_RST_CLEAR;
        end else begin
            vector_r      <= vector_nxt;
            alarm_latch_r <= alarm_latch_nxt;
        end
    end

    // The pin follows the next vector so it drops with the bit.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            interrupt_request_n_out  <= 1'b0;
            interrupt_request_n_oe_n <= 1'b1;
        end else begin
            interrupt_request_n_out  <= 1'b0;
            interrupt_request_n_oe_n <= ~((|vector_nxt) & ~suspend);
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (on_ctrl) begin
            case (req.addr)
                `E1IA_ADDR_MODE:     rdata_nxt = mode_r;
                `E1IA_ADDR_NAT_MASK: rdata_nxt = nat_mask_r;
                `E1IA_ADDR_IRQ_CTRL: rdata_nxt = irq_ctrl_r;
                `E1IA_ADDR_MASK0:    rdata_nxt = mask0_r;
                `E1IA_ADDR_MASK1:    rdata_nxt = mask1_r;
                `E1IA_ADDR_MASK2:    rdata_nxt = mask2_r;
                `E1IA_ADDR_MASK3:    rdata_nxt = mask3_r;
                default:             rdata_nxt = 8'h00;
            endcase
        end else if (on_status) begin
            if (req.addr == `E1IA_ADDR_VECTOR) begin
                rdata_nxt = vector_r;
            end else if (req.addr == `E1IA_ADDR_ALARM_LATCH) begin
                rdata_nxt = alarm_latch_r;
            end
        end else if (req.addr == `E1IA_ADDR_HDLC_MASK) begin
            if (req.page == `E1IA_PAGE_HDLC_A) begin
                rdata_nxt = hdlc_mask_r[0];
            end else if (req.page == `E1IA_PAGE_HDLC_B) begin
                rdata_nxt = hdlc_mask_r[1];
            end
        end
    end

    // Read data is captured before the clear and driven for one cycle.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata      <= 8'h00;
            rdata_oe_n <= 1'b1;
        end else begin
            if (rd_acc) begin
                rdata <= rdata_nxt;
            end
            rdata_oe_n <= ~rd_acc;
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // A read with no event in the same cycle leaves nothing set.
    property p_read_clears;
        vec_read && cat_hit == 8'h00 |=> vector_r == 8'h00
            && interrupt_request_n_oe_n;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("vector not cleared by read");

    // The acknowledge flip wipes the vector just as a read does.
    property p_ack_clears;
        ack_toggle && cat_hit == 8'h00 |=> vector_r == 8'h00;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("vector not cleared by acknowledge");

    // Every unmasked hit outside suspend and soft reset shows in the vector and on the pin.
    property p_request;
        !suspend && !soft_rst && cat_hit != 8'h00
            |=> !interrupt_request_n_oe_n && (vector_r & $past(cat_hit))
                == $past(cat_hit);
    endproperty
    a_request: assert property (p_request)
        else $error("unmasked event did not raise request");

    // The suspend bit keeps the pin released from the next cycle on.
    property p_suspend;
        irq_ctrl_r[`E1IA_BIT_SUSPEND] && !wr_acc
            |=> interrupt_request_n_oe_n;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("request raised while suspended");

    // Suspending must never disturb the stored mask words zero, one and two.
    property p_keep_masks;
        suspend && !wr_acc && !soft_rst |=> $stable(mask0_r)
            && $stable(mask1_r) && $stable(mask2_r);
    endproperty
    a_keep_masks: assert property (p_keep_masks)
        else $error("suspend altered a mask word");

    // The pin needs one cycle to reach the registered output.
    property p_pin_suspend;
        !transmit_alarm_pin ##1 !transmit_alarm_pin
            |-> interrupt_request_n_oe_n;
    endproperty
    a_pin_suspend: assert property (p_pin_suspend)
        else $error("request raised while pin held low");

    // Soft reset puts the control page masks back to their defaults.
    property p_soft_reset;
        soft_rst |=> mask0_r == 8'h00 && mask1_r == 8'hFF
            && mask2_r == 8'hFF && nat_mask_r == 8'h7F
            && vector_r == 8'h00;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset left wrong mask values");

    // A sync loss lands in the top category bit.
    property p_sync_cat;
        ev.word0[7] && !mask0_r[7] && !suspend && !soft_rst
            |=> vector_r[`E1IA_CAT_SYNC];
    endproperty
    a_sync_cat: assert property (p_sync_cat)
        else $error("sync loss did not set bit seven");

    // A slip lands in category bit two.
    property p_slip_cat;
        ev.word0[0] && !mask0_r[0] && !suspend && !soft_rst
            |=> vector_r[`E1IA_CAT_SLIP];
    endproperty
    a_slip_cat: assert property (p_slip_cat)
        else $error("slip did not set bit two");

    // The latch keeps an alarm until someone reads it.
    property p_alarm_latch;
        ev.word0[3] |=> alarm_latch_r[3] ##1 (alarm_latch_r[3]
            || $past(rd_acc));
    endproperty
    a_alarm_latch: assert property (p_alarm_latch)
        else $error("loss of signal not held in latch");

    // Soft reset also shuts the HDLC words and mask word three.
    property p_soft_reset_rest;
        soft_rst |=> hdlc_mask_r[0] == 8'hFF && hdlc_mask_r[1] == 8'hFF
            && mask3_r == 8'hFC;
    endproperty
    a_soft_reset_rest: assert property (p_soft_reset_rest)
        else $error("soft reset left HDLC or word three open");

    // The acknowledge flip also lets go of the request pin.
    property p_ack_release;
        ack_toggle && cat_hit == 8'h00 |=> interrupt_request_n_oe_n;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("acknowledge did not release request");

    // With nothing pending and no unmasked hit, nothing appears.
    // This is what keeps a fully masked source silent.
    property p_masked_quiet;
        vector_r == 8'h00 && cat_hit == 8'h00
            |=> vector_r == 8'h00 && interrupt_request_n_oe_n;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("vector set without an unmasked event");

    // The pin is only pulled while some category is pending.
    property p_pull_needs_vector;
        !interrupt_request_n_oe_n |-> vector_r != 8'h00;
    endproperty
    a_pull_needs_vector: assert property (p_pull_needs_vector)
        else $error("request pulled with an empty vector");

    // A latch read with no alarm in that cycle empties the latch.
    property p_latch_clear;
        rd_acc && on_status && req.addr == `E1IA_ADDR_ALARM_LATCH
            && alarm_ev == 8'h00 |=> alarm_latch_r == 8'h00;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("latch not cleared by read");

    // Main scenarios that the bench is meant to reach.
    c_read_clear: cover property (vector_r != 8'h00 ##1 vec_read
                                  ##1 vector_r == 8'h00);
    c_ack: cover property (vector_r != 8'h00 && ack_toggle);
    c_suspended_event: cover property (suspend && cat_hit != 8'h00);
    c_hdlc: cover property (hdlc_hit[1] && !suspend);
    c_soft_reset: cover property (soft_rst && vector_r != 8'h00);

endmodule // e1ia_top
`default_nettype wire

// ===== e1ia_regs.svh
// Summary of operation
// - Eight categories, one vector bit each.
// - Unmasked event pulls request low, sets category.
// - Reading vector clears it and releases request.
// - Toggling acknowledge bit clears like a read.
// - Every source maskable; HDLC masks on own pages.
// - Reset masks all words except word zero.
// - Suspend bit blocks interrupts, masks kept.
// - Transmit alarm pin low suspends all interrupts.
// - Synchronisation category sets vector bit seven.
// - Alarm category sets vector bit six.
// - Counter indication category sets bit five.
// - Counter overflow category sets bit four.
// - One second category sets bit three.
// - Slip category sets bit two.
// - National use bit one, signalling bit zero.
// - National use mask word layout at 19H.
// - Mask word zero layout at 1BH.
// - Mask word one layout at 1CH.
// - Mask word two layout at 1DH.
// - Mask word three layout from bit seven.
// - HDLC mask word layout at 16H.
// - Alarm latch holds bits until read.
`ifndef E1IA_REGS_SVH
`define E1IA_REGS_SVH

// Pages of the microport.
`define E1IA_PAGE_CTRL1       5'h01
`define E1IA_PAGE_STATUS      5'h04
`define E1IA_PAGE_HDLC_A      5'h0B
`define E1IA_PAGE_HDLC_B      5'h0C

// Addresses within a page.
`define E1IA_ADDR_MODE        5'h11
`define E1IA_ADDR_VECTOR      5'h12
`define E1IA_ADDR_HDLC_MASK   5'h16
`define E1IA_ADDR_NAT_MASK    5'h19
`define E1IA_ADDR_IRQ_CTRL    5'h1A
`define E1IA_ADDR_MASK0       5'h1B
`define E1IA_ADDR_MASK1       5'h1C
`define E1IA_ADDR_MASK2       5'h1D
`define E1IA_ADDR_MASK3       5'h1E
`define E1IA_ADDR_ALARM_LATCH 5'h1B

// Control bit positions.
`define E1IA_BIT_SOFT_RESET   5
`define E1IA_BIT_SUSPEND      6
`define E1IA_BIT_ACK          5

// Category bit positions in the vector.
`define E1IA_CAT_SYNC         7
`define E1IA_CAT_ALARM        6
`define E1IA_CAT_CNT_IND      5
`define E1IA_CAT_CNT_OVF      4
`define E1IA_CAT_ONE_SEC      3
`define E1IA_CAT_SLIP         2
`define E1IA_CAT_NATIONAL     1
`define E1IA_CAT_SIGNAL       0

// Reset values and implemented bits.
`define E1IA_RST_CLEAR        8'h00
`define E1IA_RST_MASKED       8'hFF
`define E1IA_NAT_USED         8'h7F
`define E1IA_MASK3_USED       8'hFC

`endif

// ===== e1ia_pkg.sv
`default_nettype none
package e1ia_pkg;

    // One microport access, sampled on the clock.
    typedef struct packed {
        logic       cs;
        logic       rd;
        logic       wr;
        logic [4:0] page;
        logic [4:0] addr;
        logic [7:0] wdata;
    } e1ia_bus_req_t;

    // Event pulses from the framer, grouped in mask word order.
    typedef struct packed {
        logic [7:0]      word0;
        logic [7:0]      word1;
        logic [7:0]      word2;
        logic [5:0]      word3;
        logic [6:0]      national;
        logic [1:0][7:0] hdlc;
    } e1ia_events_t;

endpackage
`default_nettype wire

// ===== e1ia_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host processor on the microport: makes the byte accesses and
// resolves the open-drain request line.
module e1ia_host_model (
    // Clock.
    input  wire logic                    core_clk,
    // Microport request and read answer.
    output var  e1ia_pkg::e1ia_bus_req_t req,
    input  wire logic [7:0]              rdata,
    input  wire logic                    rdata_oe_n,
    // Request pin parts and the level seen on the board.
    input  wire logic                    irq_out,
    input  wire logic                    irq_oe_n,
    output logic                         irq_n
);
    logic ack_r = 1'b0; // Last acknowledge level written.

    // The board pull-up lifts the line whenever the device lets go.
    assign irq_n = irq_oe_n ? 1'b1 : irq_out;

    initial begin
        req = '0;
    end

    // One access: strobe for one cycle, then an idle bus that carries
    // inverted values so nothing can lean on stale address or data.
    task automatic access(input logic rd, input logic [4:0] pg,
                          input logic [4:0] ad, input logic [7:0] wd,
                          output logic [7:0] d, output logic oe_n);
        @(posedge core_clk);
        req <= '{1'b1, rd, ~rd, pg, ad, wd};
        @(posedge core_clk);
        req <= '{1'b0, 1'b0, 1'b0, ~pg, ~ad, ~wd};
        #1;
        d = rdata;
        oe_n = rdata_oe_n;
    endtask

    // Control word write; a flip changes the acknowledge bit, which
    // clears a pending request without reading the vector.
    task automatic ctrl(input logic interrupt_suspend, input logic flip);
        logic [7:0] d;
        logic       o;
        ack_r = ack_r ^ flip;
        access(1'b0, 5'h01, 5'h1A, {1'b0, interrupt_suspend, ack_r, 5'h00}, d, o);
    endtask
endmodule // e1ia_host_model
`default_nettype wire

// ===== e1_interrupt_aggregator_test.sv
`timescale 1ns/1ns
`default_nettype none
module e1_interrupt_aggregator_test;
    logic                    core_clk = 1'b0;    // 100 MHz clock.
    logic                    reset = 1'b1;       // Held at start.
    logic                    transmit_alarm_pin = 1'b1;
    e1ia_pkg::e1ia_bus_req_t req;                // From the host.
    e1ia_pkg::e1ia_events_t  ev = '0;            // Event pulses.
    logic [7:0]              rdata;
    logic                    rdata_oe_n, irq_out, irq_oe_n, irq_n;
    logic [7:0]              d;                  // Scratch data.
    logic                    o;                  // Scratch enable.
    int                      error_cnt = 0;
    int                      checks_done = 0;

    // Mask words in event order, and their reset contents.
    localparam logic [9:0] LOC [7] = '{{5'h01, 5'h1B}, {5'h01, 5'h1C},
        {5'h01, 5'h1D}, {5'h01, 5'h1E}, {5'h01, 5'h19}, {5'h0C, 5'h16},
        {5'h0B, 5'h16}};
    localparam logic [52:0] MRST = {8'h00, 8'hFF, 8'hFF, 6'h3F, 7'h7F,
                                    16'hFFFF};
    // Vector bit of each source of words zero and two, by bit.
    localparam logic [2:0] CW0 [8] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h6,
        3'h6, 3'h6, 3'h7};
    localparam logic [2:0] CW2 [8] = '{3'h4, 3'h6, 3'h4, 3'h2, 3'h4,
        3'h3, 3'h4, 3'h4};

    always #5 core_clk = ~core_clk;

    e1ia_top dut (.core_clk, .reset, .req, .rdata, .rdata_oe_n, .ev,
        .transmit_alarm_pin, .interrupt_request_n_out(irq_out),
        .interrupt_request_n_oe_n(irq_oe_n));
    e1ia_host_model host (.core_clk, .req, .rdata, .rdata_oe_n,
        .irq_out, .irq_oe_n, .irq_n);

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [4:0] pg, ad, input logic [7:0] v);
        host.access(1'b0, pg, ad, v, d, o);
    endtask
    // Every read must also enable the data bus right after it is taken.
    task automatic rd(input logic [4:0] pg, ad, output logic [7:0] v);
        host.access(1'b1, pg, ad, 8'h00, v, o);
        check({7'h00, o}, 8'h00);
        // The data bus enable stands for one cycle only.
        @(posedge core_clk);
        #1;
        check({7'h00, rdata_oe_n}, 8'h01);
    endtask
    // A one-cycle burst of events, then quiet inputs.
    task automatic fire(input logic [52:0] e);
        @(posedge core_clk);
        ev <= e1ia_pkg::e1ia_events_t'(e);
        @(posedge core_clk);
        ev <= '0;
        #1;
    endtask
    task automatic pin(input logic x);
        check({7'h00, irq_n}, {7'h00, x});
    endtask
    function automatic logic [7:0] mval(input logic [52:0] m, input int k);
        case (k)
            0: return m[52:45];
            1: return m[44:37];
            2: return m[36:29];
            3: return {m[28:23], 2'b00};
            4: return {1'b0, m[22:16]};
            5: return m[15:8];
            default: return m[7:0];
        endcase
    endfunction
    task automatic setm(input logic [52:0] m);
        for (int k = 0; k < 7; k++) wr(LOC[k][9:5], LOC[k][4:0], mval(m, k));
    endtask
    task automatic chkm(input logic [52:0] m);
        logic [7:0] v;
        for (int k = 0; k < 7; k++) begin
            rd(LOC[k][9:5], LOC[k][4:0], v);
            check(v, mval(m, k));
        end
    endtask
    // Category pattern of one source, by its place in the event word.
    function automatic logic [7:0] cat(input int i);
        if (i < 16) return (i < 8) ? 8'h02 : 8'h01;
        if (i < 23) return 8'h02;
        if (i < 29) return (i < 26) ? 8'h08 : 8'h80;
        if (i < 37) return 8'h01 << CW2[i-29];
        if (i < 45) return (i == 37) ? 8'h01 : 8'h20;
        return 8'h01 << CW0[i-45];
    endfunction
    function automatic logic [7:0] expv(input logic [52:0] e, m);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 53; i++) if (e[i] && !m[i]) v |= cat(i);
        return v;
    endfunction
    function automatic logic [52:0] rnd();
        return 53'({$urandom(), $urandom()});
    endfunction

    // Hang guard, well beyond the roughly 1600 cycles the tests need.
    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end

    initial begin
        logic [52:0] m, e;
        logic [7:0]  v;
        void'($urandom(32'h0df6_b3ae));
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        chkm(MRST);
        rd(5'h04, 5'h12, v);
        check(v, 8'h00);
        pin(1'b1);
        rd(5'h04, 5'h00, v);
        check(v, 8'h00);
        $display("test reset done");
        // Each source alone, unmasked: its category only, cleared by read.
        setm('0);
        for (int i = 0; i < 53; i++) begin
            fire(53'h1 << i);
            pin(1'b0);
            rd(5'h04, 5'h12, v);
            check(v, cat(i));
            pin(1'b1);
        end
        $display("test sweep done");
        // Random masks; first all masked, then all open with all events.
        for (int n = 0; n < 30; n++) begin
            m = (n == 0) ? '1 : (n == 1) ? '0 : rnd();
            e = (n < 2) ? '1 : rnd() & rnd() & rnd();
            setm(m);
            chkm(m);
            fire(e);
            pin(expv(e, m) == 8'h00);
            rd(5'h04, 5'h12, v);
            check(v, expv(e, m));
        end
        $display("test masks done");
        // Suspend by control bit, then by the pin: vector kept, no new bits.
        setm('0);
        for (int s = 0; s < 2; s++) begin
            fire(53'h1 << 45);
            @(posedge core_clk);
            if (s == 0) host.ctrl(1'b1, 1'b0);
            else transmit_alarm_pin <= 1'b0;
            repeat (2) @(posedge core_clk);
            #1;
            pin(1'b1);
            fire('1);
            chkm('0);
            @(posedge core_clk);
            if (s == 0) host.ctrl(1'b0, 1'b0);
            else transmit_alarm_pin <= 1'b1;
            repeat (2) @(posedge core_clk);
            #1;
            pin(1'b0);
            rd(5'h04, 5'h12, v);
            check(v, 8'h04);
        end
        $display("test suspend done");
        // Acknowledge: a same-level write keeps, a flip clears.
        fire(53'h1 << 52);
        host.ctrl(1'b0, 1'b0);
        pin(1'b0);
        host.ctrl(1'b0, 1'b1);
        @(posedge core_clk);
        #1;
        pin(1'b1);
        rd(5'h04, 5'h12, v);
        check(v, 8'h00);
        $display("test ack done");
        // Alarm latch holds an event until read.
        rd(5'h04, 5'h1B, v);
        fire(53'h1 << 52);
        rd(5'h04, 5'h1B, v);
        check(v, 8'h80);
        rd(5'h04, 5'h1B, v);
        check(v, 8'h00);
        // Soft reset restores the masks and clears the vector.
        fire(53'h1 << 52);
        wr(5'h01, 5'h11, 8'h20);
        wr(5'h01, 5'h11, 8'h00);
        chkm(MRST);
        rd(5'h04, 5'h12, v);
        check(v, 8'h00);
        pin(1'b1);
        $display("test latch and soft reset done");
        stop_test();
    end
endmodule // e1_interrupt_aggregator_test
`default_nettype wire
